/* File: logic/pgd_map.vh */
// Register map, field positions and reset values of the planar datapath.
// Assumes inclusion by the datapath files only; definitions only.
`ifndef PGD_MAP_VH
`define PGD_MAP_VH

// ------------------------------------------------------------
// I/O port addresses
// ------------------------------------------------------------
`define PGD_PORT_INDEX 16'h03CE
`define PGD_PORT_DATA 16'h03CF

// ------------------------------------------------------------
// Register indexes
// ------------------------------------------------------------
`define PGD_IDX_FILL 5'h00
`define PGD_IDX_OVR 5'h01
`define PGD_IDX_CMP 5'h02
`define PGD_IDX_ROT 5'h03
`define PGD_IDX_RDP 5'h04
`define PGD_IDX_MODE 5'h05
`define PGD_IDX_INCL 5'h07
`define PGD_IDX_MASK 5'h08

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PGD_ROT_CNT 2:0
`define PGD_ROT_FUNC 4:3
`define PGD_RDP_SEL 1:0
`define PGD_MODE_WR 1:0
`define PGD_MODE_RD 3
`define PGD_MODE_OE 4
`define PGD_MODE_SHIFT 6:5

// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define PGD_FN_PASS 2'b00
`define PGD_FN_AND 2'b01
`define PGD_FN_OR 2'b10
`define PGD_FN_XOR 2'b11
`define PGD_WM_0 2'b00
`define PGD_WM_1 2'b01
`define PGD_WM_2 2'b10
`define PGD_WM_3 2'b11
`define PGD_SH_PLANAR 2'b00
`define PGD_SH_ALT 2'b01

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PGD_RST_IDX 5'h00
`define PGD_RST_NIB 4'h0
`define PGD_RST_ROT 5'h00
`define PGD_RST_MODE 7'h00
`define PGD_RST_MASK 8'hFF

`endif

/* File: logic/pgd_serialiser.v */
// Pixel serialiser: turns four plane bytes into eight 4-bit transfers.
// Assumes load is a one-cycle pulse on clk_i; pixel enable may stay high, one transfer per cycle.
`timescale 1ns/1ps
`include "pgd_map.vh"

module pgd_serialiser (
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire pix_en_i,
    input wire [1:0] shift_ctl_i,
    input wire [31:0] planes_i,
    output reg [3:0] pix_o
);

    reg [31:0] data_q;
    reg [2:0] xfer_q;
    reg [3:0] pix_c;
    reg [2:0] hi_bit;
    reg [2:0] lo_bit;
    reg [7:0] pa;
    reg [7:0] pb;

    // ------------------------------------------------------------
    // Transfer select
    // ------------------------------------------------------------
    always @* begin
        pix_c = 4'h0;
        hi_bit = 3'd0;
        lo_bit = 3'd0;
        pa = 8'h00;
        pb = 8'h00;
        if (shift_ctl_i == `PGD_SH_PLANAR) begin
            // Plane n on output n, msb first
            lo_bit = 3'd7 - xfer_q;
            pix_c = {data_q[24 + lo_bit], data_q[16 + lo_bit], data_q[8 + lo_bit], data_q[lo_bit]};
        end else if (shift_ctl_i == `PGD_SH_ALT) begin
            // Planes 0/2 pairs first, then 1/3
            pa = xfer_q[2] ? data_q[15:8] : data_q[7:0];
            pb = xfer_q[2] ? data_q[31:24] : data_q[23:16];
            hi_bit = 3'd7 - {xfer_q[1:0], 1'b0};
            lo_bit = 3'd6 - {xfer_q[1:0], 1'b0};
            pix_c = {pb[hi_bit], pb[lo_bit], pa[hi_bit], pa[lo_bit]};
        end else begin
            // One nibble per transfer, plane 0 upper first
            pa = data_q[{xfer_q[2:1], 3'b000} +: 8];
            pix_c = xfer_q[0] ? pa[3:0] : pa[7:4];
        end
    end

    // ------------------------------------------------------------
    // Shift state and output register
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_q <= 32'h0000_0000;
            xfer_q <= 3'd0;
            pix_o <= 4'h0;
        end else if (load_i) begin
            data_q <= planes_i;
            xfer_q <= 3'd0;
        end else if (pix_en_i) begin
            pix_o <= pix_c;
            xfer_q <= xfer_q + 3'd1;
        end
    end

endmodule // pgd_serialiser

/* File: logic/pgd_datapath.v */
// Planar graphics datapath: index/data registers, host write and read paths,
// read latches and the pixel serialiser. Assumes an external four-plane
// frame buffer that returns read data in the cycle after mem_rd_o.
`timescale 1ns/1ps
`include "pgd_map.vh"

module pgd_datapath #(
    parameter PLANES = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire [15:0] io_addr_i,
    input wire io_wr_i,
    input wire io_rd_i,
    input wire [7:0] io_wdata_i,
    output reg [7:0] io_rdata_o,
    input wire fb_req_i,
    input wire fb_we_i,
    input wire [15:0] fb_addr_i,
    input wire [7:0] fb_wdata_i,
    output reg fb_busy_o,
    output reg fb_rvalid_o,
    output reg [7:0] fb_rdata_o,
    input wire [3:0] host_plane_write_mask_i,
    input wire chain4_i,
    output reg [15:0] mem_addr_o,
    output reg mem_rd_o,
    output reg [3:0] mem_we_o,
    output reg [31:0] mem_wdata_o,
    input wire [31:0] mem_rdata_i,
    input wire disp_load_i,
    input wire disp_pix_en_i,
    input wire [31:0] disp_data_i,
    output wire [3:0] pix_o,
    output reg [7:0] latch_readback_o
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WR = 4'b0010;
    localparam [3:0] ST_RD = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    // Register file
    reg [4:0] index_q;
    reg [3:0] plane_fill_colour_q;
    reg [3:0] plane_override_enable_q;
    reg [3:0] compare_colour_q;
    reg [4:0] rotate_and_function_q;
    reg [1:0] read_plane_choice_q;
    reg [6:0] graphics_access_mode_q;
    reg [3:0] compare_plane_include_q;
    reg [7:0] write_bit_mask_q;

    // Access state
    reg [3:0] state_q;
    reg [15:0] addr_q;
    reg [31:0] latch_q;
    reg [1:0] rd_plane_q;

    // Combinational helpers
    reg [7:0] reg_rdata_c;
    reg [7:0] rot_c;
    reg [15:0] rot_wide;
    reg [3:0] plane_en_c;
    reg [1:0] rd_plane_c;
    reg [7:0] cmp_c;
    reg [7:0] rd_byte_c;
    wire [31:0] wr_data_c;
    wire [31:0] cmp_plane_c;

    wire [1:0] write_mode = graphics_access_mode_q[`PGD_MODE_WR];
    wire read_mode = graphics_access_mode_q[`PGD_MODE_RD];
    wire odd_even = graphics_access_mode_q[`PGD_MODE_OE];
    wire [1:0] func_sel = rotate_and_function_q[`PGD_ROT_FUNC];
    wire [2:0] rot_cnt = rotate_and_function_q[`PGD_ROT_CNT];
    wire take = fb_req_i & ~fb_busy_o;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always @* begin
        reg_rdata_c = 8'h00;
        case (index_q)
            `PGD_IDX_FILL: reg_rdata_c = {4'h0, plane_fill_colour_q};
            `PGD_IDX_OVR: reg_rdata_c = {4'h0, plane_override_enable_q};
            `PGD_IDX_CMP: reg_rdata_c = {4'h0, compare_colour_q};
            `PGD_IDX_ROT: reg_rdata_c = {3'b000, rotate_and_function_q};
            `PGD_IDX_RDP: reg_rdata_c = {6'h00, read_plane_choice_q};
            `PGD_IDX_MODE: reg_rdata_c = {1'b0, graphics_access_mode_q[6:3], 1'b0,
                graphics_access_mode_q[1:0]};
            `PGD_IDX_INCL: reg_rdata_c = {4'h0, compare_plane_include_q};
            `PGD_IDX_MASK: reg_rdata_c = write_bit_mask_q;
            default: reg_rdata_c = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Index/data port registers
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            index_q <= `PGD_RST_IDX;
            plane_fill_colour_q <= `PGD_RST_NIB;
            plane_override_enable_q <= `PGD_RST_NIB;
            compare_colour_q <= `PGD_RST_NIB;
            rotate_and_function_q <= `PGD_RST_ROT;
            read_plane_choice_q <= 2'b00;
            graphics_access_mode_q <= `PGD_RST_MODE;
            compare_plane_include_q <= `PGD_RST_NIB;
            write_bit_mask_q <= `PGD_RST_MASK;
            io_rdata_o <= 8'h00;
        end else begin
            if (io_wr_i && io_addr_i == `PGD_PORT_INDEX) begin
                index_q <= io_wdata_i[4:0];
            end
            if (io_wr_i && io_addr_i == `PGD_PORT_DATA) begin
                case (index_q)
                    `PGD_IDX_FILL: plane_fill_colour_q <= io_wdata_i[3:0];
                    `PGD_IDX_OVR: plane_override_enable_q <= io_wdata_i[3:0];
                    `PGD_IDX_CMP: compare_colour_q <= io_wdata_i[3:0];
                    `PGD_IDX_ROT: rotate_and_function_q <= io_wdata_i[4:0];
                    `PGD_IDX_RDP: read_plane_choice_q <= io_wdata_i[1:0];
                    `PGD_IDX_MODE: graphics_access_mode_q <= io_wdata_i[6:0];
                    `PGD_IDX_INCL: compare_plane_include_q <= io_wdata_i[3:0];
                    `PGD_IDX_MASK: write_bit_mask_q <= io_wdata_i;
                    default: index_q <= index_q;
                endcase
            end
            // Read data one cycle after the strobe
            if (io_rd_i) begin
                if (io_addr_i == `PGD_PORT_INDEX) begin
                    io_rdata_o <= {3'b000, index_q};
                end else if (io_addr_i == `PGD_PORT_DATA) begin
                    io_rdata_o <= reg_rdata_c;
                end else begin
                    io_rdata_o <= 8'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Rotation and plane selection for the incoming request
    // ------------------------------------------------------------
    always @* begin
        rot_wide = {fb_wdata_i, fb_wdata_i} >> rot_cnt;
        rot_c = rot_wide[7:0];
        if (chain4_i) begin
            plane_en_c = host_plane_write_mask_i & (4'b0001 << fb_addr_i[1:0]);
            rd_plane_c = fb_addr_i[1:0];
        end else if (odd_even) begin
            plane_en_c = host_plane_write_mask_i &
                (fb_addr_i[0] ? 4'b1010 : 4'b0101);
            rd_plane_c = {read_plane_choice_q[1], fb_addr_i[0]};
        end else begin
            plane_en_c = host_plane_write_mask_i;
            rd_plane_c = read_plane_choice_q;
        end
    end

    // ------------------------------------------------------------
    // Per-plane write path and compare
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PLANES; p = p + 1) begin : g_plane
            reg [7:0] src;
            reg [7:0] alu;
            reg [7:0] msk;
            reg [7:0] res;
            wire [7:0] lat = latch_q[8 * p +: 8];
            always @* begin
                msk = write_bit_mask_q;
                case (write_mode)
                    `PGD_WM_0: src = plane_override_enable_q[p] ?
                        {8{plane_fill_colour_q[p]}} : rot_c;
                    `PGD_WM_2: src = {8{fb_wdata_i[p]}};
                    `PGD_WM_3: begin
                        src = {8{plane_fill_colour_q[p]}};
                        msk = rot_c & write_bit_mask_q;
                    end
                    default: src = lat;
                endcase
                case (func_sel)
                    `PGD_FN_AND: alu = src & lat;
                    `PGD_FN_OR: alu = src | lat;
                    `PGD_FN_XOR: alu = src ^ lat;
                    default: alu = src;
                endcase
                if (write_mode == `PGD_WM_1) begin
                    res = lat;
                end else begin
                    res = (alu & msk) | (lat & ~msk);
                end
            end
            assign wr_data_c[8 * p +: 8] = res;
            // Match vector; excluded planes always match
            assign cmp_plane_c[8 * p +: 8] =
                ~(mem_rdata_i[8 * p +: 8] ^ {8{compare_colour_q[p]}}) |
                {8{~compare_plane_include_q[p]}};
        end
    endgenerate

    // ------------------------------------------------------------
    // Read result
    // ------------------------------------------------------------
    always @* begin
        cmp_c = cmp_plane_c[7:0] & cmp_plane_c[15:8] &
            cmp_plane_c[23:16] & cmp_plane_c[31:24];
        rd_byte_c = mem_rdata_i[{rd_plane_q, 3'b000} +: 8];
    end

    // ------------------------------------------------------------
    // Frame buffer access sequencer
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            addr_q <= 16'h0000;
            rd_plane_q <= 2'b00;
            latch_q <= 32'h0000_0000;
            fb_busy_o <= 1'b0;
            fb_rvalid_o <= 1'b0;
            fb_rdata_o <= 8'h00;
            mem_addr_o <= 16'h0000;
            mem_rd_o <= 1'b0;
            mem_we_o <= 4'h0;
            mem_wdata_o <= 32'h0000_0000;
        end else begin
            fb_rvalid_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_we_o <= 4'h0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        addr_q <= fb_addr_i;
                        mem_addr_o <= fb_addr_i;
                        rd_plane_q <= rd_plane_c;
                        fb_busy_o <= 1'b1;
                        if (fb_we_i) begin
                            mem_we_o <= plane_en_c;
                            mem_wdata_o <= wr_data_c;
                            state_q <= ST_WR;
                        end else begin
                            mem_rd_o <= 1'b1;
                            state_q <= ST_RD;
                        end
                    end
                end
                ST_WR: begin
                    fb_busy_o <= 1'b0;
                    state_q <= ST_IDLE;
                end
                ST_RD: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    latch_q <= mem_rdata_i;
                    fb_rdata_o <= read_mode ? cmp_c : rd_byte_c;
                    fb_rvalid_o <= 1'b1;
                    fb_busy_o <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: begin
                    fb_busy_o <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Latch readback register
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_readback_o <= 8'h00;
        end else begin
            latch_readback_o <= latch_q[{read_plane_choice_q, 3'b000} +: 8];
        end
    end

    // ------------------------------------------------------------
    // Pixel serialiser
    // ------------------------------------------------------------
    pgd_serialiser u_ser (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(disp_load_i),
        .pix_en_i(disp_pix_en_i),
        .shift_ctl_i(graphics_access_mode_q[`PGD_MODE_SHIFT]),
        .planes_i(disp_data_i),
        .pix_o(pix_o)
    );

endmodule // pgd_datapath

/* File: bench/pgd_datapath_sva.sv */
// Checker for the planar datapath: frame buffer handshake and output timing.
// Assumes it is bound to pgd_datapath and sees only that module's ports.
`timescale 1ns/1ps
module pgd_datapath_chk (
    input wire clk_i,
    input wire rst_i,
    input wire [15:0] io_addr_i,
    input wire io_rd_i,
    input wire [7:0] io_rdata_o,
    input wire fb_req_i,
    input wire fb_we_i,
    input wire [15:0] fb_addr_i,
    input wire fb_busy_o,
    input wire fb_rvalid_o,
    input wire [3:0] host_plane_write_mask_i,
    input wire [15:0] mem_addr_o,
    input wire mem_rd_o,
    input wire [3:0] mem_we_o,
    input wire disp_pix_en_i,
    input wire [3:0] pix_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    rd_seq_a: assert property (
        fb_req_i && !fb_busy_o && !fb_we_i |=> mem_rd_o && fb_busy_o
        ##1 fb_busy_o && !mem_rd_o ##1 fb_rvalid_o && !fb_busy_o) else $error("read sequence wrong");
    wr_seq_a: assert property (
        fb_req_i && !fb_busy_o && fb_we_i |=> fb_busy_o && !mem_rd_o
        ##1 !fb_busy_o && !fb_rvalid_o) else $error("write sequence wrong");
    we_mask_a: assert property (
        mem_we_o != 4'h0 |-> (mem_we_o & ~$past(host_plane_write_mask_i)) == 4'h0)
        else $error("masked plane written");
    we_cause_a: assert property (
        mem_we_o != 4'h0 |-> $past(fb_req_i) && $past(fb_we_i) && !$past(fb_busy_o))
        else $error("write without request");
    addr_pass_a: assert property (
        fb_req_i && !fb_busy_o |=> mem_addr_o == $past(fb_addr_i)) else $error("address altered");
    rvalid_once_a: assert property (
        fb_rvalid_o |=> !fb_rvalid_o) else $error("read valid too long");
    pix_hold_a: assert property (
        !$past(disp_pix_en_i) |-> $stable(pix_o)) else $error("pixel moved without enable");
    io_unmapped_a: assert property (
        io_rd_i && io_addr_i[15:1] != 15'h01E7 |=> io_rdata_o == 8'h00)
        else $error("foreign port read not zero");
endmodule // pgd_datapath_chk

/* File: bench/pgd_fb_model.sv */
// Four-plane frame buffer model, 16 words deep, answering the cycle after a read.
// Assumes the datapath's registered memory strobes on the same clock.
`timescale 1ns/1ps
module pgd_fb_model (
    input wire clk_i,
    input wire [15:0] mem_addr_i,
    input wire mem_rd_i,
    input wire [3:0] mem_we_i,
    input wire [31:0] mem_wdata_i,
    output reg [31:0] mem_rdata_o
);
    reg [31:0] mem_q [0:15];
    integer i, p;
    // Known preload so the bench can predict every read
    initial begin
        mem_rdata_o = 32'h0000_0000;
        for (i = 0; i < 16; i = i + 1) mem_q[i] = 32'h1357_9BDF ^ {8{i[3:0]}};
    end
    // Word out after a read, else the bus toggles so stale data never matches
    always @(posedge clk_i) begin
        mem_rdata_o <= mem_rd_i ? mem_q[mem_addr_i[3:0]] : ~mem_rdata_o;
        for (p = 0; p < 4; p = p + 1) begin
            if (mem_we_i[p]) mem_q[mem_addr_i[3:0]][p*8+:8] <= mem_wdata_i[p*8+:8];
        end
    end
endmodule // pgd_fb_model

/* File: bench/pgd_datapath_test.sv */
// Self-checking bench for pgd_datapath with a frame buffer model.
// Assumes the checker and model files are compiled first.
`timescale 1ns/1ps
module test_pgd_datapath;
    localparam [71:0] RMASK = 72'hFF_0F_00_7B_03_1F_0F_0F_0F;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [15:0] io_addr_i = 16'h0000;
    reg io_wr_i = 1'b0;
    reg io_rd_i = 1'b0;
    reg [7:0] io_wdata_i = 8'h00;
    reg fb_req_i = 1'b0;
    reg fb_we_i = 1'b0;
    reg [15:0] fb_addr_i = 16'h0000;
    reg [7:0] fb_wdata_i = 8'h00;
    reg [3:0] hpm = 4'hF;
    reg chain4_i = 1'b0;
    reg disp_load_i = 1'b0;
    reg disp_pix_en_i = 1'b0;
    reg [31:0] disp_data_i = 32'h0000_0000;
    wire [7:0] io_rdata_o, fb_rdata_o, latch_readback_o;
    wire fb_busy_o, fb_rvalid_o, mem_rd_o;
    wire [15:0] mem_addr_o;
    wire [3:0] mem_we_o, pix_o;
    wire [31:0] mem_wdata_o, mem_rdata_i;
    reg [31:0] seed = 32'h0001_84E7;
    reg [31:0] sh [0:15];
    reg [7:0] rg [0:8];
    reg [31:0] lat = 32'h0000_0000;
    reg [35:0] expq [$];
    reg io_rd_q = 1'b0;
    reg pix_q = 1'b0;
    integer mismatches = 0;
    integer tests_run = 0;
    integer i, k;

    always #25 clk_i = ~clk_i;

    pgd_datapath u_pgd_datapath (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .fb_req_i(fb_req_i), .fb_we_i(fb_we_i), .fb_addr_i(fb_addr_i), .fb_wdata_i(fb_wdata_i),
        .fb_busy_o(fb_busy_o), .fb_rvalid_o(fb_rvalid_o), .fb_rdata_o(fb_rdata_o),
        .host_plane_write_mask_i(hpm), .chain4_i(chain4_i), .mem_addr_o(mem_addr_o),
        .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .disp_load_i(disp_load_i), .disp_pix_en_i(disp_pix_en_i),
        .disp_data_i(disp_data_i), .pix_o(pix_o), .latch_readback_o(latch_readback_o));
    pgd_fb_model u_pgd_fb_model (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
        .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

    // ------------------------------------------------------------
    // Expected values
    // ------------------------------------------------------------
    function [31:0] lfsr(input [31:0] s);
        lfsr = s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
    endfunction
    function [7:0] exp_rd(input [15:0] a);
        reg [1:0] s;
        integer p;
        begin
            s = chain4_i ? a[1:0] : rg[5][4] ? {rg[4][1], a[0]} : rg[4][1:0];
            exp_rd = rg[5][3] ? 8'hFF : lat[s*8+:8];
            for (p = 0; p < 4; p = p + 1)
                if (rg[5][3] && rg[7][p]) exp_rd = exp_rd & ~(lat[p*8+:8] ^ {8{rg[2][p]}});
        end
    endfunction
    function [35:0] exp_wr(input [15:0] a, input [7:0] d);
        reg [15:0] t;
        reg [7:0] m, lt, s;
        reg [1:0] wm;
        integer p;
        begin
            wm = rg[5][1:0];
            t = {d, d} >> rg[3][2:0];
            m = (wm == 2'd3) ? t[7:0] & rg[8] : rg[8];
            for (p = 0; p < 4; p = p + 1) begin
                lt = lat[p*8+:8];
                s = (wm == 2'd0 && !rg[1][p]) ? t[7:0] : {8{rg[0][p]}};
                if (wm == 2'd2) s = {8{d[p]}};
                case (rg[3][4:3])
                    2'd1: s = s & lt;
                    2'd2: s = s | lt;
                    2'd3: s = s ^ lt;
                    default: s = s;
                endcase
                exp_wr[p*8+:8] = (wm == 2'd1) ? lt : (s & m) | (lt & ~m);
            end
            exp_wr[35:32] = hpm & (chain4_i ? 4'h1 << a[1:0] :
                rg[5][4] ? (a[0] ? 4'hA : 4'h5) : 4'hF);
        end
    endfunction
    function [3:0] exp_px(input [1:0] f, input [31:0] d, input integer k);
        reg [7:0] b, c;
        integer j;
        begin
            j = 2 * (k % 4);
            b = d[(k/4)*8+:8];
            c = d[(k/4+2)*8+:8];
            exp_px = {c[7-j], c[6-j], b[7-j], b[6-j]};
            if (f == 2'd0) exp_px = {d[31-k], d[23-k], d[15-k], d[7-k]};
            b = d[(k/2)*8+:8];
            if (f == 2'd2) exp_px = k[0] ? b[3:0] : b[7:4];
        end
    endfunction

    // ------------------------------------------------------------
    // Drivers and scoreboard
    // ------------------------------------------------------------
    task cmp(input [35:0] got, input [35:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task pop_cmp(input [35:0] got);
        if (expq.size() == 0) cmp(got, ~got);
        else cmp(got, expq.pop_front());
    endtask
    task io_cyc(input wr, input [15:0] a, input [7:0] d);
        begin
            @(posedge clk_i); #1;
            io_wr_i = wr;
            io_rd_i = !wr;
            io_addr_i = a;
            io_wdata_i = d;
            @(posedge clk_i); #1;
            io_wr_i = 1'b0;
            io_rd_i = 1'b0;
        end
    endtask
    task wreg(input [4:0] x, input [7:0] v);
        begin
            io_cyc(1'b1, 16'h03CE, {3'h0, x});
            io_cyc(1'b1, 16'h03CF, v);
            rg[x] = v & RMASK[x*8+:8];
        end
    endtask
    task rreg(input [15:0] a, input [4:0] x, input [7:0] e);
        begin
            io_cyc(1'b1, 16'h03CE, {3'h0, x});
            expq.push_back({28'h0, e});
            io_cyc(1'b0, a, 8'h00);
        end
    endtask
    task fb(input we, input [15:0] a, input [7:0] d);
        reg [35:0] w;
        integer p;
        begin
            if (!we) lat = sh[a[3:0]];
            if (!we) expq.push_back({28'h0, exp_rd(a)});
            w = exp_wr(a, d);
            if (we && w[35:32] != 4'h0) expq.push_back(w);
            for (p = 0; p < 4; p = p + 1) if (we && w[32+p]) sh[a[3:0]][p*8+:8] = w[p*8+:8];
            @(posedge clk_i); #1;
            fb_req_i = 1'b1;
            fb_we_i = we;
            fb_addr_i = a;
            fb_wdata_i = d;
            @(posedge clk_i); #1;
            fb_req_i = 1'b0;
            repeat (3) @(posedge clk_i);
            #1;
        end
    endtask
    // Mark results that appear at the next edge
    always @(posedge clk_i) begin
        io_rd_q <= io_rd_i;
        pix_q <= disp_pix_en_i;
    end
    // Settled results are compared against the oldest note
    always @(negedge clk_i) begin
        if (fb_rvalid_o === 1'b1) pop_cmp({28'h0, fb_rdata_o});
        if (mem_we_o !== 4'h0) pop_cmp({mem_we_o, mem_wdata_o});
        if (io_rd_q) pop_cmp({28'h0, io_rdata_o});
        if (pix_q) pop_cmp({32'h0, pix_o});
    end
    task final_report;
        begin
            if (expq.size() != 0) mismatches = mismatches + 1;
            $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #500_000;
        mismatches = mismatches + 1;
        final_report;
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        for (i = 0; i < 16; i = i + 1) sh[i] = 32'h1357_9BDF ^ {8{i[3:0]}};
        for (i = 0; i < 9; i = i + 1) rg[i] = (i == 8) ? 8'hFF : 8'h00;
        repeat (3) @(posedge clk_i);
        #1 rst_i = 1'b0;
        for (i = 0; i < 9; i = i + 1) begin
            rreg(16'h03CF, i, rg[i]);
            wreg(i, 8'hFF);
            rreg(16'h03CF, i, rg[i]);
        end
        rreg(16'h03C4, 5'h0, 8'h00);
        rreg(16'h03CE, 5'h05, 8'h05);
        $display("test registers done");
        for (i = 0; i < 16; i = i + 1) begin
            seed = lfsr(seed);
            hpm = seed[3:0];
            wreg(0, seed[7:4]);
            wreg(1, seed[11:8]);
            wreg(3, {i[1:0], seed[14:12]});
            wreg(8, seed[22:15]);
            wreg(4, seed[24:23]);
            wreg(5, {6'h0, i[3:2]});
            fb(1'b0, seed[31:16], 8'h00);
            fb(1'b1, seed[31:16], seed[15:8]);
        end
        $display("test write modes done");
        for (i = 0; i < 16; i = i + 1) begin
            seed = lfsr(seed);
            chain4_i = i[0];
            hpm = seed[3:0];
            wreg(2, seed[7:4]);
            wreg(7, seed[11:8]);
            wreg(4, seed[13:12]);
            wreg(5, {3'h0, i[1], i[2], 3'h0});
            fb(1'b0, seed[31:16], 8'h00);
            fb(1'b1, seed[31:16], seed[23:16]);
        end
        $display("test addressing done");
        for (i = 0; i < 4; i = i + 1) begin
            wreg(4, i);
            repeat (2) @(posedge clk_i);
            #1 cmp({28'h0, latch_readback_o}, {28'h0, lat[i*8+:8]});
        end
        $display("test latch readback done");
        for (i = 0; i < 3; i = i + 1) begin
            seed = lfsr(seed);
            wreg(5, {1'b0, i[1:0], 5'h00});
            for (k = 0; k < 8; k = k + 1) expq.push_back({32'h0, exp_px(i[1:0], seed, k)});
            @(posedge clk_i); #1;
            disp_data_i = seed;
            disp_load_i = 1'b1;
            @(posedge clk_i); #1;
            disp_load_i = 1'b0;
            disp_pix_en_i = 1'b1;
            repeat (8) @(posedge clk_i);
            #1 disp_pix_en_i = 1'b0;
        end
        $display("test serialiser done");
        repeat (4) @(posedge clk_i);
        final_report;
    end
endmodule // test_pgd_datapath

bind pgd_datapath pgd_datapath_chk u_pgd_datapath_chk (.clk_i(clk_i), .rst_i(rst_i),
    .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .fb_req_i(fb_req_i),
    .fb_we_i(fb_we_i), .fb_addr_i(fb_addr_i), .fb_busy_o(fb_busy_o),
    .fb_rvalid_o(fb_rvalid_o), .host_plane_write_mask_i(host_plane_write_mask_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o),
    .disp_pix_en_i(disp_pix_en_i), .pix_o(pix_o));
